/* hw/dac_update_ctrl.sv */
// update control: recompute engine, wired busy line, load strobe, power-down
//
// Operation
// - data, gain or offset write starts recompute; busy held low until done
// - writes accepted while busy; no output register update while busy
// - busy pin bidirectional, shared wired line; released when own work done
// - finished device waits while any other device holds busy low
// - load strobe low transfers selected corrected values to outputs
// - load falling while busy is remembered and done when busy ends
// - load held low updates outputs each time busy ends
// - bank-select write asserts busy for 500 ns
// - addressed channels of one write recomputed one after another
// - busy width is (channels + 1) x 600 ns + 300 ns
// - load only updates channels recomputed or whose select bit flipped since last load
// - select bit 0 takes bank A, 1 takes bank B
// - select register n bit k steers channel 8n+k
// - power-down bit grounds outputs, keeps registers, clearing restores them
// - thermal enable plus over-temperature acts like power-down
// - entering thermal shutdown sets flag bit 4 of the control register
// - shutdown latched until software clears thermal enable
// - separate corrected registers for bank A and bank B per channel
// - while clear is low every load strobe is ignored
// - data writes go to bank A input when bank bit 0, else bank B
//
// Local design decisions: the address-and-strobe port and the register addresses.
`include "dac_update_regs.svh"

module dac_update_ctrl
  import dac_update_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              load_outputs_n_i,
  input  wire logic              force_ground_n_i,
  input  wire logic              busy_n_i,
  output logic                   busy_n_o,
  output logic                   busy_n_oe_o,
  input  wire logic              over_temp_i,
  output chan_codes_t            dac_code_o,
  output logic                   outputs_grounded_o
);

  state_t r;
  state_t n;

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  logic [31:0] hit;
  code_t       pick [32];
  logic [4:0]  cmd_ch;
  logic [4:0]  cmd_mask;

  assign cmd_ch = reg_wdata_i[`CMD_CH_LSB +: 5];

  always_comb begin
    case (reg_wdata_i[`CMD_CNT_LSB +: 2])
      2'h0: cmd_mask = 5'h1F;
      2'h1: cmd_mask = 5'h1C;
      2'h2: cmd_mask = 5'h18;
      default: cmd_mask = 5'h00;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_ch
      // aligned groups of 1, 4, 8 or 32 channels
      assign hit[g] = (((5'(g)) ^ cmd_ch) & cmd_mask) == 5'h00;
      // select register g/8, bit g%8
      assign pick[g] = r.sel[g / 8][g % 8] ? r.cor_b[g] : r.cor_a[g];
    end
  endgenerate

  function automatic logic [6:0] first_set(input logic [63:0] v);
    logic [6:0] res;
    res = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, 6'(i)};
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [6:0] nxt;
  logic       load_fall;
  logic       line_busy;
  logic       clear_ok;
  logic       do_load;
  logic [7:0] ctrl_val;
  logic [7:0] old_sel;

  always_comb begin
    n         = r;
    nxt       = first_set(r.pend);
    old_sel   = 8'h00;
    ctrl_val  = 8'h00;
    ctrl_val[`CTRL_PD_BIT]   = r.pd;
    ctrl_val[`CTRL_TEN_BIT]  = r.ten;
    ctrl_val[`CTRL_BANK_BIT] = r.bank;
    ctrl_val[`CTRL_TFLG_BIT] = r.tflag;

    // pins: load, clear, busy line, over-temperature
    n.s1 = {over_temp_i, busy_n_i, force_ground_n_i, load_outputs_n_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // only a level on which the last two stages agree is taken
    n.stab = (r.s2 & ~(r.s2 ^ r.s3)) | (r.stab & (r.s2 ^ r.s3));
    load_fall = r.stab[0] & ~n.stab[0];
    clear_ok  = r.stab[1];
    // own work or anybody else pulling the shared line low
    line_busy = r.busy_oe | ~r.stab[2] | (r.eng != E_IDLE)
              | (r.pend != 64'h0);

    // ----------------------------------------
    // output load
    // ----------------------------------------
    do_load = ~line_busy & clear_ok & (r.load_pend | ~r.stab[0]);
    if (do_load) begin
      for (int c = 0; c < 32; c++) begin
        if (r.dirty[c]) begin
          n.dac[c] = pick[c];
        end
      end
      n.dirty = 32'h0;
    end
    if (!clear_ok) begin
      n.load_pend = 1'b0;
    end else if (do_load) begin
      n.load_pend = 1'b0;
    end
    // a new edge in the completing cycle survives
    if (load_fall && clear_ok) begin
      n.load_pend = 1'b1;
    end

    // ----------------------------------------
    // recompute engine, one channel at a time
    // ----------------------------------------
    case (r.eng)
      E_IDLE: begin
        if (nxt[6]) begin
          n.cur           = nxt[5:0];
          n.pend[nxt[5:0]] = 1'b0;
          n.eng           = E_CALC;
          n.cnt           = 7'(`STAGE_CYC - 1);
        end
      end
      E_CALC: begin
        if (r.cnt != 7'h00) begin
          n.cnt = r.cnt - 7'h01;
        end else begin
          // correction arithmetic lives elsewhere; value passes through
          if (r.cur[5]) begin
            n.cor_b[r.cur[4:0]] = r.in_b[r.cur[4:0]];
          end else begin
            n.cor_a[r.cur[4:0]] = r.in_a[r.cur[4:0]];
          end
          n.dirty[r.cur[4:0]] = 1'b1;
          if (nxt[6]) begin
            n.cur            = nxt[5:0];
            n.pend[nxt[5:0]] = 1'b0;
            n.cnt            = 7'(`STAGE_CYC - 1);
          end else begin
            n.eng = E_FINAL;
            n.cnt = 7'(`STAGE_CYC - 1);
          end
        end
      end
      E_FINAL: begin
        if (r.cnt != 7'h00) begin
          n.cnt = r.cnt - 7'h01;
        end else begin
          n.eng = E_TAIL;
          n.cnt = 7'(`TAIL_CYC - 1);
        end
      end
      default: begin
        if (r.cnt != 7'h00) begin
          n.cnt = r.cnt - 7'h01;
        end else begin
          n.eng = E_IDLE;
        end
      end
    endcase

    if (r.sel_cnt != 6'h00) begin
      n.sel_cnt = r.sel_cnt - 6'h01;
    end

    // ----------------------------------------
    // register writes (after engine: set wins)
    // ----------------------------------------
    if (reg_wr_i) begin
      if (reg_addr_i == `CTRL_OFS) begin
        n.pd   = reg_wdata_i[`CTRL_PD_BIT];
        n.ten  = reg_wdata_i[`CTRL_TEN_BIT];
        n.bank = reg_wdata_i[`CTRL_BANK_BIT];
        if (reg_wdata_i[`CTRL_TFLG_BIT]) begin
          n.tflag = 1'b0;
        end
      end else if (reg_addr_i >= `SEL0_OFS && reg_addr_i <= `SEL3_OFS
                   && reg_addr_i[1:0] == 2'h0) begin
        old_sel = r.sel[2'(reg_addr_i[7:2] - 6'h01)];
        n.sel[2'(reg_addr_i[7:2] - 6'h01)] = reg_wdata_i[7:0];
        // channels whose bank flipped must reload
        n.dirty[8 * (reg_addr_i[7:2] - 6'h01) +: 8] =
          n.dirty[8 * (reg_addr_i[7:2] - 6'h01) +: 8] | (old_sel ^ reg_wdata_i[7:0]);
        n.sel_cnt = 6'(`SEL_BUSY_CYC);
      end else if (reg_addr_i == `CMD_OFS
                   && reg_wdata_i[`CMD_MODE_LSB +: 2] != 2'h0) begin
        for (int c = 0; c < 32; c++) begin
          if (hit[c]) begin
            if (reg_wdata_i[`CMD_MODE_LSB +: 2] == `MODE_INPUT) begin
              if (r.bank) begin
                n.in_b[c] = reg_wdata_i[13:0];
              end else begin
                n.in_a[c] = reg_wdata_i[13:0];
              end
            end
            // gain and offset writes recompute the selected bank too
            n.pend[{r.bank, 5'(c)}] = 1'b1;
          end
        end
      end
    end

    // ----------------------------------------
    // thermal shutdown and power-down
    // ----------------------------------------
    if (!n.ten) begin
      n.shut = 1'b0;
    end else if (r.stab[3]) begin
      n.shut = 1'b1;
      if (!r.shut) begin
        n.tflag = 1'b1;
      end
    end
    // registers untouched; only the output stage is grounded
    n.grounded = n.pd | n.shut | ~clear_ok;

    // ----------------------------------------
    // busy pin drive
    // ----------------------------------------
    n.busy_n  = 1'b0;
    // queued work keeps the line low across the idle step between runs
    n.busy_oe = (n.eng != E_IDLE) | (n.sel_cnt != 6'h00)
              | ((r.eng != E_IDLE) & (n.pend != 64'h0));

    // ----------------------------------------
    // register reads, data one cycle later
    // ----------------------------------------
    n.rdata = 32'h0;
    if (reg_rd_i) begin
      if (reg_addr_i == `CTRL_OFS) begin
        n.rdata = {24'h0, ctrl_val};
      end else if (reg_addr_i >= `SEL0_OFS && reg_addr_i <= `SEL3_OFS
                   && reg_addr_i[1:0] == 2'h0) begin
        n.rdata = {24'h0, r.sel[2'(reg_addr_i[7:2] - 6'h01)]};
      end else if (reg_addr_i == `STAT_OFS) begin
        n.rdata = {26'h0, r.load_pend, r.stab[2], r.grounded, r.shut,
                   line_busy, r.busy_oe};
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r           <= '0;
      r.sel       <= {4{`SEL_RESET}};
      r.pd        <= 1'(`CTRL_RESET >> `CTRL_PD_BIT);
      r.eng       <= E_IDLE;
      r.s1        <= 4'h7;
      r.s2        <= 4'h7;
      r.s3        <= 4'h7;
      r.stab      <= 4'h7;
      r.busy_n    <= 1'b0;
      r.busy_oe   <= 1'b0;
      r.grounded  <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata_o        = r.rdata;
  assign busy_n_o           = r.busy_n;
  assign busy_n_oe_o        = r.busy_oe;
  assign dac_code_o         = r.dac;
  assign outputs_grounded_o = r.grounded;

endmodule

/* hw/dac_update_pkg.sv */
// types for the converter update-control block
package dac_update_pkg;

  typedef logic [13:0]            code_t;
  typedef logic [31:0][13:0]      chan_codes_t;
  typedef enum logic [1:0] {
    E_IDLE,
    E_CALC,
    E_FINAL,
    E_TAIL
  } eng_state_t;

  typedef struct packed {
    chan_codes_t      in_a;
    chan_codes_t      in_b;
    chan_codes_t      cor_a;
    chan_codes_t      cor_b;
    chan_codes_t      dac;
    logic [63:0]      pend;
    logic [31:0]      dirty;
    logic [3:0][7:0]  sel;
    logic             pd;
    logic             ten;
    logic             bank;
    logic             tflag;
    logic             shut;
    eng_state_t       eng;
    logic [6:0]       cnt;
    logic [5:0]       cur;
    logic [5:0]       sel_cnt;
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       s3;
    logic [3:0]       stab;
    logic             load_pend;
    logic             busy_oe;
    logic             busy_n;
    logic             grounded;
    logic [31:0]      rdata;
  } state_t;

endpackage

/* hw/dac_update_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DAC_UPDATE_REGS_SVH
`define DAC_UPDATE_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CTRL_OFS      8'h00
`define SEL0_OFS      8'h04
`define SEL1_OFS      8'h08
`define SEL2_OFS      8'h0C
`define SEL3_OFS      8'h10
`define CMD_OFS       8'h14
`define STAT_OFS      8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_PD_BIT   0
`define CTRL_TEN_BIT  1
`define CTRL_BANK_BIT 2
`define CTRL_TFLG_BIT 4
`define CTRL_RESET    8'h00
`define SEL_RESET     8'h00

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CMD_MODE_LSB  14
`define CMD_CH_LSB    16
`define CMD_CNT_LSB   22
`define MODE_GAIN     2'h1
`define MODE_OFFSET   2'h2
`define MODE_INPUT    2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS        10
`define STAGE_NS      600
`define TAIL_NS       300
`define SEL_BUSY_NS   500
`define STAGE_CYC     ((`STAGE_NS + `CLK_NS - 1) / `CLK_NS)
`define TAIL_CYC      ((`TAIL_NS + `CLK_NS - 1) / `CLK_NS)
`define SEL_BUSY_CYC  ((`SEL_BUSY_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* verification/dac_update_ctrl_assertions.sv */
// port checker for the update-control block
`include "dac_update_regs.svh"
module dac_update_ctrl_assertions
  import dac_update_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        load_outputs_n_i,
  input wire logic        force_ground_n_i,
  input wire logic        busy_n_i,
  input wire logic        busy_n_o,
  input wire logic        busy_n_oe_o,
  input wire logic        over_temp_i,
  input wire chan_codes_t dac_code_o,
  input wire logic        outputs_grounded_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic cmd_wr;
  logic ctl_wr;
  assign cmd_wr = reg_wr_i && reg_addr_i == `CMD_OFS && reg_wdata_i[15:14] != 2'h0;
  assign ctl_wr = reg_wr_i && reg_addr_i == `CTRL_OFS;
  property p_drive_low; busy_n_oe_o |-> !busy_n_o; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("busy drive not low");
  property p_cmd_busy; cmd_wr && !busy_n_oe_o |-> ##2 busy_n_oe_o; endproperty
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("no busy after command");
  property p_width_one;
    cmd_wr && !busy_n_oe_o && reg_wdata_i[23:22] == 2'h0
      |-> ##151 busy_n_oe_o ##1 !busy_n_oe_o;
  endproperty
  a_width_one: assert property (p_width_one)
    else $error("single channel busy width wrong");
  property p_sel_busy; reg_wr_i && reg_addr_i == `SEL0_OFS |=> busy_n_oe_o [*8]; endproperty
  a_sel_busy: assert property (p_sel_busy)
    else $error("no busy after select write");
  property p_busy_hold;
    $past(busy_n_oe_o) && $past(busy_n_oe_o, 2) |-> $stable(dac_code_o);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("outputs changed while busy");
  property p_line_hold; !busy_n_i [*6] |-> $stable(dac_code_o); endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("outputs changed while line low");
  property p_clear_hold; !force_ground_n_i [*6] |-> $stable(dac_code_o); endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("outputs changed while clear low");
  // clear pin effect must be gone before grounding counts as latched
  property p_ground_kept;
    force_ground_n_i [*6] ##0 (outputs_grounded_o && !ctl_wr && !$past(ctl_wr))
      |=> outputs_grounded_o;
  endproperty
  a_ground_kept: assert property (p_ground_kept)
    else $error("grounding dropped without control write");
  c_update: cover property (!$stable(dac_code_o));
  c_queued: cover property (cmd_wr && busy_n_oe_o);
  c_thermal: cover property (outputs_grounded_o && over_temp_i);
endmodule

bind dac_update_ctrl dac_update_ctrl_assertions u_chk (.*);

/* verification/dac_update_ctrl_test.sv */
// self-checking bench for the update-control block
`include "dac_update_regs.svh"
module dac_update_ctrl_test
  import dac_update_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        force_ground_n_i = 1'b1, over_temp_i = 1'b0;
  logic        pulse = 1'b0, hold = 1'b0, other = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic        busy_n_o, busy_n_oe_o, grounded, load_n, other_oe, line;
  chan_codes_t dac_code_o;
  int          error_cnt = 0, total_checks = 0, b;
  // pull-up on the shared line
  assign line = !((busy_n_oe_o && !busy_n_o) || other_oe);
  always #5 clk_i = ~clk_i;
  dac_update_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .load_outputs_n_i(load_n),
    .force_ground_n_i(force_ground_n_i), .busy_n_i(line), .busy_n_o(busy_n_o),
    .busy_n_oe_o(busy_n_oe_o), .over_temp_i(over_temp_i), .dac_code_o(dac_code_o),
    .outputs_grounded_o(grounded));
  host_model u_host (.clk_i(clk_i), .pulse_i(pulse), .hold_i(hold), .other_i(other),
    .load_outputs_n_o(load_n), .other_oe_o(other_oe));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  function automatic logic [31:0] cmd(logic [1:0] m, logic [4:0] c, logic [1:0] k, code_t d);
    return {8'h00, k, 1'b0, c, m, d};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic idle();
    wait_n(3);
    for (int n = 0; n < 3000 && busy_n_oe_o !== 1'b0; n++) @(posedge clk_i);
  endtask
  task automatic ld();
    @(posedge clk_i);
    pulse <= 1'b1;
    @(posedge clk_i);
    pulse <= 1'b0;
    wait_n(12);
  endtask
  task automatic chc(input int c, input code_t e);
    chk(32'(dac_code_o[c]), 32'(e));
  endtask
  task automatic gnd(input logic e);
    wait_n(6);
    chk(32'(grounded), 32'(e));
  endtask
  // busy cycles seen over a fixed window
  task automatic blen(input int w, output int n);
    n = 0;
    repeat (w) begin
      #1 n += int'(busy_n_oe_o === 1'b1);
      @(posedge clk_i);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_basic();
    rd(`SEL0_OFS, 32'h0);
    wr(`CMD_OFS, cmd(2'h3, 5'd3, 2'h0, 14'h1ABC));
    blen(200, b);
    chk(32'(b), 32'd150);
    chc(3, 14'h0);
    ld();
    chc(3, 14'h1ABC);
    chc(4, 14'h0);
    for (int m = 1; m < 3; m++) begin
      wr(`CMD_OFS, cmd(2'(m), 5'd3, 2'h0, 14'h1ABC));
      idle();
    end
  endtask
  task automatic t_toggle();
    wr(`CTRL_OFS, 32'h4);
    wr(`CMD_OFS, cmd(2'h3, 5'd3, 2'h0, 14'h0555));
    idle();
    wr(`CTRL_OFS, 32'h0);
    wr(`SEL0_OFS, 32'h08);
    blen(80, b);
    chk(32'(b), 32'd50);
    ld();
    chc(3, 14'h0555);
    wr(`SEL0_OFS, 32'h00);
    idle();
    ld();
    chc(3, 14'h1ABC);
  endtask
  task automatic t_queue();
    wr(`CMD_OFS, cmd(2'h3, 5'd9, 2'h1, 14'h0222));
    fork
      blen(500, b);
      begin
        wait_n(60);
        wr(`CMD_OFS, cmd(2'h3, 5'd20, 2'h0, 14'h0333));
        ld();
        chc(20, 14'h0);
      end
    join
    chk(32'(b), 32'd390);
    for (int c = 8; c < 12; c++) chc(c, 14'h0222);
    chc(20, 14'h0333);
  endtask
  task automatic t_shared();
    other <= 1'b1;
    wr(`CMD_OFS, cmd(2'h3, 5'd0, 2'h0, 14'h0111));
    idle();
    ld();
    chc(0, 14'h0);
    rd(`STAT_OFS, 32'h22);
    wait_n(1);
    other <= 1'b0;
    wait_n(12);
    chc(0, 14'h0111);
  endtask
  task automatic t_hold();
    hold <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`CMD_OFS, cmd(2'h3, 5'd1, 2'h0, 14'h0444 + 14'(i)));
      idle();
      wait_n(12);
      chc(1, 14'h0444 + 14'(i));
    end
    hold <= 1'b0;
  endtask
  task automatic t_clear();
    force_ground_n_i <= 1'b0;
    wr(`CMD_OFS, cmd(2'h3, 5'd2, 2'h0, 14'h0777));
    idle();
    ld();
    chc(2, 14'h0);
    force_ground_n_i <= 1'b1;
    wait_n(12);
    chc(2, 14'h0);
    ld();
    chc(2, 14'h0777);
  endtask
  task automatic t_power();
    wr(`CTRL_OFS, 32'h1);
    gnd(1'b1);
    chc(3, 14'h1ABC);
    wr(`CTRL_OFS, 32'h2);
    gnd(1'b0);
    over_temp_i <= 1'b1;
    gnd(1'b1);
    over_temp_i <= 1'b0;
    gnd(1'b1);
    rd(`CTRL_OFS, 32'h12);
    wr(`CTRL_OFS, 32'h0);
    gnd(1'b0);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    wait_n(2);
    rst_n_i <= 1'b1;
    t_basic();
    t_toggle();
    t_queue();
    t_shared();
    t_hold();
    t_clear();
    t_power();
    summarize();
  end
  // whole sequence needs well under 5000 cycles
  initial begin
    #300000;
    error_cnt++;
    summarize();
  end
endmodule

/* verification/host_model.sv */
// controller side: load strobe driver and a second device on the busy line
module host_model (
  input  wire logic clk_i,
  input  wire logic pulse_i,
  input  wire logic hold_i,
  input  wire logic other_i,
  output logic      load_outputs_n_o,
  output logic      other_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  // strobe kept low past the device's pin synchroniser
  always @(posedge clk_i) begin
    if (pulse_i) cnt <= 3'h5;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
  assign load_outputs_n_o = !(hold_i || cnt != 3'h0);
  assign other_oe_o       = other_i;
endmodule
